// ### caf_filter_cfg.v
// Acceptance filter configuration registers and identifier compare.
// Overview of operation
// [RL1] Sixteen filters each hold sixteen writable extended identifier match bits.
// [RL2] A set match bit requires the frame identifier bit to be one.
// [RL3] A clear match bit requires the frame identifier bit to be zero.
// [RL4] One 16-bit register holds 2-bit mask selects for filters 0-7, cleared at reset.
// [RL5] Select code 00, 01, 10 picks masks 0, 1, 2; code 11 is reserved.
// [RL6] Only bits where the selected mask bit is set are compared.
//
// Chosen here: the plain strobed port and the placing of the registers.
`include "caf_defs.vh"
module caf_filter_cfg (
    input  wire        clk,
    input  wire        nrst,
    input  wire [5:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire [15:0] rx_ext_id,
    input  wire        rx_id_valid,
    output reg  [15:0] filter_hit,
    output reg         hit_valid
);
    // ======================================================================
    // Decoding helpers
    function [15:0] mask_pick;
        input [1:0]  sel;
        input [15:0] m0;
        input [15:0] m1;
        input [15:0] m2;
        begin
            case (sel) // RL5
                `CAF_SEL_MASK0: mask_pick = m0;
                `CAF_SEL_MASK1: mask_pick = m1;
                `CAF_SEL_MASK2: mask_pick = m2;
                default:        mask_pick = 16'h0000;
            endcase
        end
    endfunction
    function is_eid_addr;
        input [5:0] a;
        begin
            is_eid_addr = (a[5:4] == 2'h0);
        end
    endfunction

    function [15:0] word_of;
        input [255:0] all;
        input integer idx;
        begin
            word_of = all[idx*16 +: 16];
        end
    endfunction

    function [1:0] sel_field;
        input [15:0]  sel_reg;
        input integer n;
        begin
            sel_field = sel_reg[n*2 +: 2];
        end
    endfunction

    // ======================================================================
    // Registers
    reg  [15:0]  msksel_r;
    reg  [15:0]  mask0_r;
    reg  [15:0]  mask1_r;
    reg  [15:0]  mask2_r;
    reg  [15:0]  last_hit_r;
    reg  [15:0]  rdata_nxt;
    wire [255:0] eid_all;
    wire [15:0]  hit_nxt;
    wire         eid_we;
    wire         msksel_we;
    wire         mask0_we;
    wire         mask1_we;
    wire         mask2_we;
    genvar       f;

    // ======================================================================
    // Write decode. A write to an unmapped or read-only word raises no
    // enable and is dropped.
    assign eid_we    = wr && is_eid_addr(addr); // RL1
    assign msksel_we = wr && (addr == `CAF_ADDR_MSKSEL_LO); // RL4
    assign mask0_we  = wr && (addr == `CAF_ADDR_MASK0); // RL6
    assign mask1_we  = wr && (addr == `CAF_ADDR_MASK1); // RL6
    assign mask2_we  = wr && (addr == `CAF_ADDR_MASK2); // RL6

    // ======================================================================
    // Match bit store. Its words are not reset, so software must write a
    // filter's match bits before it relies on that filter's hits.
    caf_ram u_eid (
        .clk       (clk),
        .we        (eid_we),
        .waddr     (addr[3:0]),
        .wdata     (wdata),
        .raddr     (addr[3:0]),
        .rdata     (),
        .all_words (eid_all)
    );

    // ======================================================================
    // Mask source select register, filter 7 at the top, filter 0 at the bottom.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            msksel_r <= `CAF_MSKSEL_RST; // RL4
        end else if (msksel_we) begin
            msksel_r <= wdata; // RL4
        end
    end

    // ======================================================================
    // Acceptance masks. A set bit makes that identifier bit take part in
    // the compare; all masks clear at reset, so every filter with a legal
    // select accepts any identifier until software narrows it.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask0_r <= `CAF_MASK_RST;
        end else if (mask0_we) begin
            mask0_r <= wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask1_r <= `CAF_MASK_RST;
        end else if (mask1_we) begin
            mask1_r <= wdata;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask2_r <= `CAF_MASK_RST;
        end else if (mask2_we) begin
            mask2_r <= wdata;
        end
    end

    // ======================================================================
    // Compare. Filters 8-15 have no select here and always use mask 0.
    // A reserved select gives an all-zero mask but is treated as no match,
    // so a misconfigured filter can never accept everything.
    generate
        for (f = 0; f < `CAF_NFILT; f = f + 1) begin : g_filt
            wire [15:0] care;
            wire [15:0] diff;
            wire        rsvd;
            if (f < `CAF_NSEL) begin : g_sel
                assign care = mask_pick(sel_field(msksel_r, f), mask0_r, mask1_r, mask2_r); // RL5
                assign rsvd = (sel_field(msksel_r, f) == `CAF_SEL_RSVD); // RL5
            end else begin : g_fix
                assign care = mask0_r;
                assign rsvd = 1'b0;
            end
            assign diff       = word_of(eid_all, f) ^ rx_ext_id; // RL2 RL3
            assign hit_nxt[f] = ((diff & care) == 16'h0000) && !rsvd; // RL6
        end
    endgenerate

    // ======================================================================
    // Hit outputs. filter_hit keeps the last result until the next id, and
    // the same word is kept for software in the read-only hit register.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hit_valid <= 1'b0;
        end else begin
            hit_valid <= rx_id_valid;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            filter_hit <= 16'h0000;
        end else if (rx_id_valid) begin
            filter_hit <= hit_nxt;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_hit_r <= 16'h0000;
        end else if (rx_id_valid) begin
            last_hit_r <= hit_nxt;
        end
    end

    // ======================================================================
    // Read port. The answer is registered on the strobe edge, stands for
    // exactly the next cycle and is zero otherwise, so a stale word never
    // lingers on the bus. Match bits are taken from the flat copy of the
    // store so that every read source comes through the same register.
    always @* begin
        rdata_nxt = 16'h0000;
        if (rd) begin
            if (is_eid_addr(addr)) begin
                rdata_nxt = word_of(eid_all, addr[3:0]); // RL1
            end else begin
                case (addr)
                    `CAF_ADDR_MSKSEL_LO: rdata_nxt = msksel_r; // RL4
                    `CAF_ADDR_MASK0:     rdata_nxt = mask0_r;
                    `CAF_ADDR_MASK1:     rdata_nxt = mask1_r;
                    `CAF_ADDR_MASK2:     rdata_nxt = mask2_r;
                    `CAF_ADDR_HITS:      rdata_nxt = last_hit_r;
                    default:             rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_nxt;
        end
    end
endmodule // caf_filter_cfg

// ### caf_defs.vh
// Constants for the acceptance filter configuration block.
`ifndef CAF_DEFS_VH
`define CAF_DEFS_VH
// ======================================================================
// Register map (word addresses on the plain register port)
`define CAF_ADDR_W          6
`define CAF_ADDR_EID_BASE   6'h00
`define CAF_ADDR_MSKSEL_LO  6'h10
`define CAF_ADDR_MASK0      6'h11
`define CAF_ADDR_MASK1      6'h12
`define CAF_ADDR_MASK2      6'h13
`define CAF_ADDR_HITS       6'h14
// ======================================================================
// Field layout and reset values
`define CAF_NFILT           16
`define CAF_NSEL            8
`define CAF_SEL_W           2
`define CAF_SEL_MASK0       2'h0
`define CAF_SEL_MASK1       2'h1
`define CAF_SEL_MASK2       2'h2
`define CAF_SEL_RSVD        2'h3
`define CAF_MSKSEL_RST      16'h0000
`define CAF_MASK_RST        16'h0000
`define CAF_EID_RST         16'h0000
`endif

// ### caf_ram.v
// Sixteen-word store of extended identifier match bits, one word per filter.
module caf_ram (
    input  wire        clk,
    input  wire        we,
    input  wire [3:0]  waddr,
    input  wire [15:0] wdata,
    input  wire [3:0]  raddr,
    output reg  [15:0] rdata,
    output wire [255:0] all_words
);
    reg [15:0] mem [0:15];
    genvar g;
    // ======================================================================
    // Storage
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_flat
            assign all_words[g*16 +: 16] = mem[g];
        end
    endgenerate
endmodule // caf_ram

// ### caf_node.sv
// Remote node model that hands received identifiers to the block.
module caf_node (
    input  wire         clk,
    output logic [15:0] rx_ext_id,
    output logic        rx_id_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_ext_id   = 16'hFFFF;
        rx_id_valid = 1'b0;
    end
    // Idle id lines carry the inverse of the last id, so stale data differs from the last id in every bit.
    task automatic send(input logic [15:0] id);
        @(posedge clk);
        {rx_ext_id, rx_id_valid} <= {id, 1'b1};
        @(posedge clk);
        {rx_ext_id, rx_id_valid} <= {~id, 1'b0};
    endtask
endmodule // caf_node

// ### caf_chk_asserts.sv
// Port assertions for the filter configuration block.
module caf_chk (
    input wire        clk,
    input wire        nrst,
    input wire [5:0]  addr,
    input wire [15:0] wdata,
    input wire        wr,
    input wire        rd,
    input wire [15:0] rdata,
    input wire        rx_id_valid,
    input wire [15:0] filter_hit,
    input wire        hit_valid
);
    reg [15:0] m0_r;
    reg [1:0]  s0_r;
    always @(posedge clk or negedge nrst)
        if (!nrst) {m0_r, s0_r} <= 18'h00000;
        else if (wr && addr == 6'h11) m0_r <= wdata;
        else if (wr && addr == 6'h10) s0_r <= wdata[1:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_HIT: assert property (rx_id_valid |=> hit_valid) else $error("no hit");
    AST_HOLD: assert property (!rx_id_valid |=> !hit_valid && $stable(filter_hit))
        else $error("hold");
    AST_EID: assert property (wr && addr < 6'h10 ##1 rd && addr == $past(addr)
        |=> rdata == $past(wdata, 2)) else $error("eid");
    AST_SEL: assert property (wr && addr == 6'h10 ##1 rd && addr == 6'h10
        |=> rdata == $past(wdata, 2)) else $error("sel");
    AST_RSVD: assert property (rx_id_valid && s0_r == 2'h3 |=> !filter_hit[0])
        else $error("rsvd");
    AST_MASK: assert property (rx_id_valid && m0_r == 16'h0000 |=> filter_hit[8])
        else $error("mask");
endmodule // caf_chk
bind caf_filter_cfg caf_chk u_chk (.*);

// ### testbench.sv
// Self-checking testbench for the filter configuration block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rx_id_valid, hit_valid;
    logic [5:0]  addr = 6'h00;
    logic [15:0] wdata = 16'h0000, rdata, rx_ext_id, filter_hit;
    int          errors = 0, total_checks = 0;
    caf_filter_cfg u_dut (.*);
    caf_node u_node (.*);
    initial forever #2 clk = ~clk;
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        {addr, wdata, wr, rd} <= {a, d, w, !w};
        if (w) begin
            @(posedge clk);
            {wr, rd} <= 2'h1;
        end
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", rdata, d);
    endtask
    task automatic rx(input logic [15:0] id, input logic [15:0] e);
        u_node.send(id);
        #1 check("hit", filter_hit, e);
        check("hit_valid", {15'h0000, hit_valid}, 16'h0001);
    endtask
    task automatic results();
        $display("%0d checks %0d errors", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        acc(1'b0, 6'h10, 16'h0000);
        acc(1'b0, 6'h3F, 16'h0000);
        for (int n = 0; n < 16; n++) acc(1'b1, 6'(n), 16'hA5C3);
        rx(16'h0000, 16'hFFFF);
        acc(1'b1, 6'h10, 16'h001B);
        acc(1'b1, 6'h12, 16'hFFFF);
        rx(16'hA5C2, 16'hFFFA);
        rx(16'hA5C7, 16'hFFFA);
        acc(1'b1, 6'h11, 16'h0004);
        rx(16'hA5C7, 16'h0002);
        rx(16'hA5C3, 16'hFFFE);
        acc(1'b0, 6'h14, 16'hFFFE);
        results();
    end
endmodule // testbench
